//--- common/power_seq_cfg.svh
// power_seq_cfg.svh: offsets, field positions, reset values, timing counts
// assumes a 125 MHz system clock and a 32.768 kHz internal tick
`ifndef POWER_SEQ_CFG_SVH
`define POWER_SEQ_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define REG_EVENT 8'h03
`define REG_SENSE 8'h05
`define REG_STATE 8'h06
`define REG_CHARGER 8'h1a
`define REG_PWR_CTL 8'h1b
`define REG_MODE_CFG 8'h1c

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CHG_VSEL_LSB 0
`define CHG_EN_BIT 3
`define CHARGER_RESET 4'h0
`define PWR_DLY_LSB 4
`define PWR_INV_BIT 6
`define PWR_DLY_RESET 2'h1
`define MODE_SLEEP_BIT 0
`define MODE_LONGPRESS_BIT 1
`define MODE_RESTART_BIT 2
`define MODE_CFG_RESET 3'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SYS_CLK_HZ 125000000
`define SLOW_CLK_HZ 32768
`define TICK_DIV (`SYS_CLK_HZ / `SLOW_CLK_HZ)
`define THERM_DEBOUNCE_US 8000
`define THERM_DEBOUNCE_TICKS \
  ((`THERM_DEBOUNCE_US * `SLOW_CLK_HZ + 999999) / 1000000)
`define LONG_PRESS_MS 4000
`define LONG_PRESS_TICKS ((`LONG_PRESS_MS * `SLOW_CLK_HZ + 999) / 1000)
`define LOWPOWER_SYNC_TICKS 3

`endif

//--- common/power_seq_pkg.sv
// power_seq_pkg: types shared by the power sequencer modules
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package power_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON,
    ST_SLEEP,
    ST_STANDBY,
    ST_BACKUP
  } power_state_t;
endpackage

`default_nettype wire

//--- common/lowpower_if.sv
// lowpower_if: standby request path between sequencer and qualifier
// assumes the request level is already synchronised to sys_clk
`default_nettype none

interface lowpower_if;
  logic tick;
  logic reqSync;
  logic invert;
  logic [1:0] delaySel;
  logic qualified;

  modport ctrl (output tick, output reqSync, output invert,
    output delaySel, input qualified);
  modport qual (input tick, input reqSync, input invert,
    input delaySel, output qualified);
endinterface

`default_nettype wire

//--- src/pin_sync.sv
// pin_sync: two-flop synchroniser for a group of pin levels
// assumes the inputs are asynchronous levels, not pulses
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // levels
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // ---------------------------------------------------------------
  // per bit stages
  // ---------------------------------------------------------------
  // stage1 is read by stage2 only, to keep metastability contained
  always_comb begin
    next_st = st;
    next_st.stage1 = pinIn;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinSync = st.stage2;
endmodule

`default_nettype wire

//--- src/lowpower_qualifier.sv
// lowpower_qualifier: polarity and hold-off for the standby request
// assumes tick is a one-cycle pulse at the 32 kHz rate
`include "power_seq_cfg.svh"
`default_nettype none

module lowpower_qualifier
  import power_seq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // request path
  lowpower_if.qual lp
);
  typedef struct packed {
    logic qualified;
    logic [2:0] cnt;
  } qual_t;

  qual_t st;
  qual_t next_st;
  logic req;
  logic [2:0] target;

  // ---------------------------------------------------------------
  // polarity and delay
  // ---------------------------------------------------------------
  always_comb begin
    req = lp.reqSync ^ lp.invert;
    target = 3'(`LOWPOWER_SYNC_TICKS) + {1'b0, lp.delaySel};
    next_st = st;
    if (req == st.qualified) begin
      next_st.cnt = 3'h0;
    end else if (lp.tick) begin
      // a change must hold for the full count, glitches restart it
      if (st.cnt + 3'h1 >= target) begin
        next_st.qualified = req;
        next_st.cnt = 3'h0;
      end else begin
        next_st.cnt = st.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lp.qualified = st.qualified;
endmodule

`default_nettype wire

//--- src/power_state_ctrl.sv
// power_state_ctrl: power mode machine, thermal and backup charger control
// assumes analog comparators give levels; register port from the i2c block
`include "power_seq_cfg.svh"
`default_nettype none

module power_state_ctrl
  import power_seq_pkg::*;
#(
  parameter int LONG_PRESS_TICKS = `LONG_PRESS_TICKS,
  parameter int THERM_TICKS = `THERM_DEBOUNCE_TICKS,
  parameter int TICK_DIV = `TICK_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // host pins
  input wire logic enPin,
  input wire logic lowpower_request_pin,
  // analog indications
  input wire logic vinAboveRise,
  input wire logic vinBelowFall,
  input wire logic thermShutdown,
  input wire logic [3:0] tempAbove,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // open-drain pins
  output logic irqOutNOut,
  output logic irqOutNOe,
  output logic powerGoodOutNOut,
  output logic powerGoodOutNOe,
  // backup charger
  output logic backupChargeEnable,
  output logic [2:0] backupChargeVoltageSelect,
  output logic chargeCurrentHighLevel,
  // regulator side
  output logic [2:0] powerState,
  output logic standbyMirrorLoad
);
  localparam int HW = $clog2(LONG_PRESS_TICKS + 1);
  localparam int TW = $clog2(THERM_TICKS + 1);
  localparam int DW = $clog2(TICK_DIV + 1);
  localparam int SW = 9;

  typedef struct packed {
    power_state_t state;
    logic supplyValid;
    logic thermLock;
    logic [TW-1:0] thermCnt;
    logic [HW-1:0] holdCnt;
    logic restartPending;
    logic firstUpDone;
    logic mirrorPulse;
    logic [3:0] tempPrev;
    logic [3:0] events;
    logic [3:0] charger;
    logic pwrInvert;
    logic [1:0] pwrDelay;
    logic [2:0] modeCfg;
    logic [7:0] rdData;
    logic [DW-1:0] divCnt;
    logic tick;
  } ctrl_t;

  ctrl_t st;
  ctrl_t next_st;
  logic [SW-1:0] syncOut;
  logic enSync;
  logic vinRiseSync;
  logic vinFallSync;
  logic thermSync;
  logic [3:0] tempSync;
  logic turnOn;
  logic powerOff;
  logic longPressMode;
  logic sleepSel;
  logic [3:0] clearMask;
  logic [7:0] readMux;

  lowpower_if lp ();

  // ---------------------------------------------------------------
  // synchronisers and standby qualifier
  // ---------------------------------------------------------------
  pin_sync #(
    .W(SW)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    // bit order matters, the index assigns below depend on it
    .pinIn({
      enPin,
      lowpower_request_pin,
      vinAboveRise,
      vinBelowFall,
      thermShutdown,
      tempAbove
    }),
    .pinSync(syncOut)
  );

  assign enSync = syncOut[8];
  assign lp.reqSync = syncOut[7];
  assign vinRiseSync = syncOut[6];
  assign vinFallSync = syncOut[5];
  assign thermSync = syncOut[4];
  assign tempSync = syncOut[3:0];
  assign lp.tick = st.tick;
  assign lp.invert = st.pwrInvert;
  assign lp.delaySel = st.pwrDelay;

  lowpower_qualifier u_qual (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .lp(lp)
  );

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (regAddr)
      `REG_EVENT: readMux = {4'h0, st.events};
      `REG_SENSE: readMux = {2'h0, st.supplyValid, thermSync,
        tempSync};
      `REG_STATE: readMux = {5'h00, st.state};
      `REG_CHARGER: readMux = {4'h0, st.charger};
      `REG_PWR_CTL: readMux = {1'b0, st.pwrInvert, st.pwrDelay, 4'h0};
      `REG_MODE_CFG: readMux = {5'h00, st.modeCfg};
      default: readMux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // decoded conditions
  // ---------------------------------------------------------------
  always_comb begin
    longPressMode = st.modeCfg[`MODE_LONGPRESS_BIT];
    sleepSel = st.modeCfg[`MODE_SLEEP_BIT];
    // thermal lock and supply validity both gate a turn-on
    turnOn = st.supplyValid && enSync && !st.thermLock;
    // long press compares a tick count, so it is a ticks-accurate hold
    if (longPressMode) begin
      powerOff = !enSync && (st.holdCnt >= HW'(LONG_PRESS_TICKS));
    end else begin
      powerOff = !enSync;
    end
    clearMask = 4'h0;
    if (regWrEn && regAddr == `REG_EVENT) begin
      clearMask = regWrData[3:0];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.mirrorPulse = 1'b0;

    // ---------------------------------------------------------------
    // 32 kHz tick from the system clock
    // ---------------------------------------------------------------
    if (st.divCnt >= DW'(TICK_DIV - 1)) begin
      next_st.divCnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.divCnt = st.divCnt + DW'(1);
      next_st.tick = 1'b0;
    end

    // supply hysteresis: set on rising level, cleared on falling level
    if (vinFallSync) begin
      next_st.supplyValid = 1'b0;
    end else if (vinRiseSync) begin
      next_st.supplyValid = 1'b1;
    end

    // temperature events, set wins over a clear in the same cycle
    next_st.tempPrev = tempSync;
    next_st.events = (st.events & ~clearMask)
      | (tempSync ^ st.tempPrev);

    // ---------------------------------------------------------------
    // thermal debounce
    // ---------------------------------------------------------------
    if (!thermSync) begin
      next_st.thermCnt = '0;
    end else if (st.tick && st.thermCnt < TW'(THERM_TICKS)) begin
      next_st.thermCnt = st.thermCnt + TW'(1);
    end
    if (!thermSync) begin
      next_st.thermLock = 1'b0;
    end

    // enable pin low hold counter, saturating
    if (enSync) begin
      next_st.holdCnt = '0;
    end else if (st.tick && st.holdCnt < HW'(LONG_PRESS_TICKS)) begin
      next_st.holdCnt = st.holdCnt + HW'(1);
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (regWrEn) begin
      case (regAddr)
        `REG_CHARGER: next_st.charger = regWrData[3:0];
        `REG_PWR_CTL: begin
          next_st.pwrInvert = regWrData[`PWR_INV_BIT];
          next_st.pwrDelay = regWrData[`PWR_DLY_LSB+:2];
        end
        `REG_MODE_CFG: next_st.modeCfg = regWrData[2:0];
        default: next_st.modeCfg = st.modeCfg;
      endcase
    end
    if (regRdEn) begin
      next_st.rdData = readMux;
    end

    // ---------------------------------------------------------------
    // power state machine
    // ---------------------------------------------------------------
    case (st.state)
      ST_BACKUP: begin
        // turn-on ignored here, only the supply returning leaves
        if (st.supplyValid) begin
          next_st.state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (!st.supplyValid) begin
          next_st.state = ST_BACKUP;
        end else if (turnOn || (st.restartPending && !st.thermLock)) begin
          // a pending restart obeys the thermal lock like a turn-on
          next_st.state = ST_ON;
          next_st.restartPending = 1'b0;
          if (!st.firstUpDone) begin
            next_st.firstUpDone = 1'b1;
            next_st.mirrorPulse = 1'b1;
          end
        end
      end
      ST_ON, ST_STANDBY: begin
        if (!st.supplyValid) begin
          next_st.state = ST_BACKUP;
        end else if (st.thermCnt >= TW'(THERM_TICKS)) begin
          next_st.state = ST_OFF;
          next_st.thermLock = 1'b1;
        end else if (powerOff) begin
          // a restart must see a fresh hold, not the saturated count
          next_st.holdCnt = '0;
          if (sleepSel) begin
            next_st.state = ST_SLEEP;
          end else begin
            next_st.state = ST_OFF;
            next_st.restartPending = st.modeCfg[`MODE_RESTART_BIT];
          end
        end else if (st.state == ST_ON && lp.qualified) begin
          next_st.state = ST_STANDBY;
        end else if (st.state == ST_STANDBY && !lp.qualified) begin
          next_st.state = ST_ON;
        end
      end
      ST_SLEEP: begin
        if (!st.supplyValid) begin
          next_st.state = ST_BACKUP;
        end else if (st.thermCnt >= TW'(THERM_TICKS)) begin
          next_st.state = ST_OFF;
          // the lock keeps the enable pin from waking it while hot
          next_st.thermLock = 1'b1;
        end else if (enSync) begin
          next_st.state = ST_ON;
        end
      end
      default: next_st.state = ST_OFF;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.state <= ST_OFF;
      st.charger <= `CHARGER_RESET;
      st.pwrDelay <= `PWR_DLY_RESET;
      st.modeCfg <= `MODE_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    regRdData = st.rdData;
    powerState = st.state;
    standbyMirrorLoad = st.mirrorPulse;
    backupChargeVoltageSelect = st.charger[`CHG_VSEL_LSB+:3];
    // charging draws on the main supply, so never in OFF or backup
    backupChargeEnable = st.charger[`CHG_EN_BIT]
      && st.supplyValid
      && st.state != ST_OFF && st.state != ST_BACKUP;
    chargeCurrentHighLevel = (st.state == ST_ON);
    irqOutNOut = 1'b0;
    irqOutNOe = (|st.events) && (st.state == ST_ON
      || st.state == ST_SLEEP || st.state == ST_STANDBY);
    powerGoodOutNOut = 1'b0;
    powerGoodOutNOe = (st.state != ST_ON);
  end
endmodule

`default_nettype wire

//--- sim/power_state_ctrl_properties.sv
// power_state_ctrl_properties: port-level checks of the power sequencer
// assumes binding onto power_state_ctrl, one clock, async active-low reset
`default_nettype none

module power_state_ctrl_checker
  import power_seq_pkg::*;
#(
  parameter int LONG_PRESS_TICKS = 8,
  parameter int THERM_TICKS = 4,
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // watched inputs
  input wire logic vinAboveRise,
  input wire logic vinBelowFall,
  input wire logic thermShutdown,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  // watched outputs
  input wire logic irqOutNOe,
  input wire logic powerGoodOutNOe,
  input wire logic backupChargeEnable,
  input wire logic [2:0] backupChargeVoltageSelect,
  input wire logic chargeCurrentHighLevel,
  input wire logic [2:0] powerState
);
  timeunit 1ns;
  timeprecision 1ps;
  logic chgEn;
  int thermCnt;

  // shadow of the enable bit; counts the unbroken thermal alarm
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chgEn <= 1'b0;
      thermCnt <= 0;
    end else begin
      if (regWrEn && regAddr == 8'h1a) begin
        chgEn <= regWrData[3];
      end
      thermCnt <= thermShutdown ? thermCnt + 1 : 0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_chg_bit;
    backupChargeEnable |-> chgEn;
  endproperty
  a_chg_bit: assert property (p_chg_bit)
    else $error("charger runs with enable bit clear");
  property p_vsel;
    regWrEn && regAddr == 8'h1a |=>
      backupChargeVoltageSelect == $past(regWrData[2:0]);
  endproperty
  a_vsel: assert property (p_vsel)
    else $error("voltage code not taken from write");
  property p_current;
    chargeCurrentHighLevel == (powerState == ST_ON);
  endproperty
  a_current: assert property (p_current)
    else $error("charge current level wrong for state");
  property p_off_nochg;
    powerState == ST_OFF |-> !backupChargeEnable;
  endproperty
  a_off_nochg: assert property (p_off_nochg)
    else $error("charging while off");
  property p_uv_nochg;
    vinBelowFall [*6] |-> !backupChargeEnable;
  endproperty
  a_uv_nochg: assert property (p_uv_nochg)
    else $error("charging during undervoltage");
  property p_therm_off;
    thermCnt == (THERM_TICKS + 3) * TICK_DIV + 4 |->
      !(powerState inside {ST_ON, ST_SLEEP, ST_STANDBY});
  endproperty
  a_therm_off: assert property (p_therm_off)
    else $error("no power off after thermal debounce");
  property p_therm_lock;
    thermShutdown [*4] ##0 powerState == ST_OFF |=> powerState != ST_ON;
  endproperty
  a_therm_lock: assert property (p_therm_lock)
    else $error("turned on during thermal lock");
  property p_rise_on;
    $changed(powerState) && powerState == ST_ON |-> $past(vinAboveRise, 2);
  endproperty
  a_rise_on: assert property (p_rise_on)
    else $error("power up without valid supply");
  property p_irq;
    irqOutNOe |-> powerState inside {ST_ON, ST_SLEEP, ST_STANDBY};
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt driven in wrong state");
  property p_pgood;
    powerGoodOutNOe == (powerState != ST_ON);
  endproperty
  a_pgood: assert property (p_pgood)
    else $error("power-good does not follow ON state");
  property p_on_fall;
    powerState == ST_ON && vinBelowFall |-> ##[1:6] powerState == ST_BACKUP;
  endproperty
  a_on_fall: assert property (p_on_fall)
    else $error("no backup state after supply fall");
  property p_backup_hold;
    (!vinAboveRise) [*4] ##0 powerState == ST_BACKUP |=>
      powerState == ST_BACKUP;
  endproperty
  a_backup_hold: assert property (p_backup_hold)
    else $error("left backup state without supply");

  c_standby: cover property (powerState == ST_STANDBY);
  c_sleep: cover property (powerState == ST_SLEEP);
  c_backup: cover property ($rose(powerState == ST_BACKUP));
endmodule

`default_nettype wire

//--- sim/host_pins.sv
// host_pins: host processor model driving the enable and standby pins
// assumes requests come from the bench sequence; pins move at falling edge
`default_nettype none

module host_pins (
  // clock
  input wire logic sys_clk,
  // requests
  input wire logic enReq,
  input wire logic stbyReq,
  input wire logic lowpower_polarity_invert,
  // pins
  output logic enPin,
  output logic lowpower_request_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // host knows the programmed polarity and drives the pin to match
  always @(negedge sys_clk) begin
    enPin <= enReq;
    lowpower_request_pin <= stbyReq ^ lowpower_polarity_invert;
  end
endmodule

`default_nettype wire

//--- sim/power_state_ctrl_tb.sv
// power_state_ctrl_tb: self-checking bench of the power sequencer
// assumes short counts: 4 clocks a tick, 8 tick long press, 4 tick debounce
`default_nettype none

module power_state_ctrl_tb
  import power_seq_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LP = 8;
  localparam int TH = 4;
  localparam int TD = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic vinAboveRise = 1'b0;
  logic vinBelowFall = 1'b1;
  logic thermShutdown = 1'b0;
  logic [3:0] tempAbove = 4'h0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic enReq = 1'b0;
  logic stbyReq = 1'b0;
  logic lowpower_polarity_invert = 1'b0;
  logic enPin, lpPin, irqOutNOe, powerGoodOutNOe, backupChargeEnable;
  logic chargeCurrentHighLevel, standbyMirrorLoad, rdTaken;
  logic [7:0] regRdData;
  logic [2:0] backupChargeVoltageSelect, powerState;
  logic [31:0] seed = 32'hbd6afc45;
  logic [7:0] expQ[$];
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int mirrorCnt = 0;

  always #4 sys_clk = ~sys_clk;

  host_pins host (.sys_clk, .enReq, .stbyReq, .lowpower_polarity_invert, .enPin,
    .lowpower_request_pin(lpPin));
  power_state_ctrl #(.LONG_PRESS_TICKS(LP), .THERM_TICKS(TH),
    .TICK_DIV(TD)) dut (.sys_clk, .resetn, .enPin,
    .lowpower_request_pin(lpPin), .vinAboveRise, .vinBelowFall,
    .thermShutdown, .tempAbove, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .irqOutNOut(), .irqOutNOe, .powerGoodOutNOut(),
    .powerGoodOutNOe, .backupChargeEnable, .backupChargeVoltageSelect,
    .chargeCurrentHighLevel, .powerState, .standbyMirrorLoad);

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic test_done;
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    expQ.push_back(e);
    @(negedge sys_clk);
    regRdEn = 1'b0;
  endtask
  task automatic waitSt(input logic [2:0] st, input int lim, output int n);
    n = 0;
    while (powerState !== st && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk({5'h0, powerState}, {5'h0, st});
  endtask

  // read data lands one edge after the strobe; a stuck run counts as bad
  always @(posedge sys_clk) begin
    rdTaken <= regRdEn;
    cycles++;
    if (standbyMirrorLoad === 1'b1) begin
      mirrorCnt++;
    end
    if (cycles > 5000) begin
      num_errors++;
      test_done();
    end
  end
  always @(negedge sys_clk) begin
    if (rdTaken === 1'b1) begin
      chk(regRdData, expQ.pop_front());
    end
  end

  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    int n;
    int d;
    logic [7:0] t;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    rd(8'h1a, 8'h00);
    rd(8'h1b, 8'h10);
    rd(8'h7f, 8'h00);
    waitSt(ST_BACKUP, 10, n);
    wr(8'h1a, 8'h08);
    vinAboveRise = 1'b1;
    vinBelowFall = 1'b0;
    waitSt(ST_OFF, 10, n);
    chk(powerGoodOutNOe, 1'b1);
    chk(backupChargeEnable, 1'b0);
    enReq = 1'b1;
    waitSt(ST_ON, 10, n);
    chk(powerGoodOutNOe, 1'b0);
    chk(chargeCurrentHighLevel, 1'b1);
    chk(backupChargeEnable, 1'b1);
    @(negedge sys_clk);
    chk(mirrorCnt[7:0], 8'h01);
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      t = {4'h0, seed[3], i[2:0]};
      wr(8'h1a, t);
      rd(8'h1a, t);
      chk({5'h0, backupChargeVoltageSelect}, {5'h0, i[2:0]});
      chk(backupChargeEnable, seed[3]);
    end
    seed = xorshift(seed);
    t = {4'h0, seed[3:0] | 4'h1};
    tempAbove = t[3:0];
    repeat (6) @(negedge sys_clk);
    rd(8'h05, 8'h20 | t);
    rd(8'h03, t);
    chk(irqOutNOe, 1'b1);
    wr(8'h03, 8'h0f);
    rd(8'h03, 8'h00);
    chk(irqOutNOe, 1'b0);
    tempAbove = 4'h0;
    repeat (6) @(negedge sys_clk);
    rd(8'h03, t);
    wr(8'h03, 8'h0f);
    // every polarity and delay code, timed from the request
    for (int k = 0; k < 8; k++) begin
      d = k % 4;
      wr(8'h1b, {1'b0, k[2], d[1:0], 4'h0});
      lowpower_polarity_invert = k[2];
      stbyReq = 1'b1;
      waitSt(ST_STANDBY, 60, n);
      chk(n >= (2 + d) * TD + 2 && n <= (4 + d) * TD, 1'b1);
      chk(chargeCurrentHighLevel, 1'b0);
      stbyReq = 1'b0;
      waitSt(ST_ON, 60, n);
    end
    wr(8'h1c, 8'h00);
    enReq = 1'b0;
    waitSt(ST_OFF, 10, n);
    enReq = 1'b1;
    waitSt(ST_ON, 10, n);
    wr(8'h1c, 8'h01);
    enReq = 1'b0;
    waitSt(ST_SLEEP, 10, n);
    chk(chargeCurrentHighLevel, 1'b0);
    enReq = 1'b1;
    waitSt(ST_ON, 10, n);
    wr(8'h1c, 8'h02);
    enReq = 1'b0;
    repeat ((LP - 2) * TD) @(negedge sys_clk);
    chk({5'h0, powerState}, {5'h0, ST_ON});
    waitSt(ST_OFF, 4 * TD + 8, n);
    enReq = 1'b1;
    waitSt(ST_ON, 10, n);
    wr(8'h1c, 8'h06);
    enReq = 1'b0;
    waitSt(ST_OFF, (LP + 2) * TD + 8, n);
    waitSt(ST_ON, 10, n);
    enReq = 1'b1;
    thermShutdown = 1'b1;
    waitSt(ST_OFF, (TH + 3) * TD + 8, n);
    chk(n >= TH * TD && n <= (TH + 1) * TD, 1'b1);
    repeat (20) @(negedge sys_clk);
    chk({5'h0, powerState}, {5'h0, ST_OFF});
    thermShutdown = 1'b0;
    waitSt(ST_ON, 10, n);
    wr(8'h1a, 8'h08);
    chk(backupChargeEnable, 1'b1);
    vinAboveRise = 1'b0;
    vinBelowFall = 1'b1;
    waitSt(ST_BACKUP, 10, n);
    chk(backupChargeEnable, 1'b0);
    chk(powerGoodOutNOe, 1'b1);
    repeat (20) @(negedge sys_clk);
    chk({5'h0, powerState}, {5'h0, ST_BACKUP});
    chk(mirrorCnt[7:0], 8'h01);
    test_done();
  end
endmodule

bind power_state_ctrl power_state_ctrl_checker #(
  .LONG_PRESS_TICKS(LONG_PRESS_TICKS), .THERM_TICKS(THERM_TICKS),
  .TICK_DIV(TICK_DIV)) props (.sys_clk, .resetn, .vinAboveRise,
  .vinBelowFall, .thermShutdown, .regAddr, .regWrData, .regWrEn, .irqOutNOe,
  .powerGoodOutNOe, .backupChargeEnable, .backupChargeVoltageSelect,
  .chargeCurrentHighLevel, .powerState);

`default_nettype wire
